// ### hdl/pdb_engine.sv
// Pin engine: drives address, chip select and strobes for one transfer
module pdb_engine
  import pdb_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Request from register file
  pdb_xfer_if.eng                 xf,
  // Pins
  output logic [ADDR_W-1:0]       addr_pins_o,
  output logic                    address_pin_fourteen_o,
  output logic                    cs1_o,
  output logic                    rd_strobe_o,
  output logic                    wr_strobe_o,
  input  wire logic [RDATA_W-1:0] data_pins_i
);
  pdb_state_t               state;
  pdb_state_t               next_state;
  logic [3:0]               cnt;
  logic [3:0]               next_cnt;
  logic [ADDR_W-1:0]        addr;
  logic [ADDR_W-1:0]        next_addr;
  logic                     cs1;
  logic                     next_cs1;
  logic                     rd;
  logic                     next_rd;
  logic [RDATA_W-1:0]       rdata;
  logic [RDATA_W-1:0]       next_rdata;

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_addr  = addr;
    next_cs1   = cs1;
    next_rd    = rd;
    next_rdata = rdata;
    case (state)
      PDB_IDLE: begin
        if (xf.start) begin
          next_state = PDB_STROBE;
          next_cnt   = 4'(STROBE_CYC);
          next_addr  = xf.addr;
          next_cs1   = xf.cs1;
          next_rd    = xf.is_read;
        end
      end
      PDB_STROBE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_state = PDB_DONE;
          if (rd) begin
            next_rdata = data_pins_i;
          end
        end
      end
      default: begin
        next_state = PDB_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= PDB_IDLE;
      cnt   <= 4'h0;
      addr  <= RST_ADDR;
      cs1   <= 1'b0;
      rd    <= 1'b0;
      rdata <= RST_DATA;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      addr  <= next_addr;
      cs1   <= next_cs1;
      rd    <= next_rd;
      rdata <= next_rdata;
    end
  end

  assign addr_pins_o = addr;
  assign cs1_o                  = (state != PDB_IDLE) && cs1;
  assign address_pin_fourteen_o = 1'b0;
  assign rd_strobe_o = (state == PDB_STROBE) && rd;
  assign wr_strobe_o = (state == PDB_STROBE) && !rd;
  assign xf.busy  = (state != PDB_IDLE);
  assign xf.done  = (state == PDB_DONE);
  assign xf.rdata = rdata;
endmodule

// ### hdl/pdb_pkg.sv
// Package: register map, field layout and reset values of the dual-buffer port
package pdb_pkg;
  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 11;
  localparam int          RDATA_W         = 16;
  localparam int          OFS_W           = 8;
  // Register byte offsets on the bus
  localparam logic [7:0]  OFS_CONTROL     = 8'h00;
  localparam logic [7:0]  OFS_DATA_IN     = 8'h04;
  localparam logic [7:0]  OFS_WRITE_ADDR  = 8'h08;
  localparam logic [7:0]  OFS_READ_ADDR   = 8'h0c;
  localparam logic [7:0]  OFS_READ_DATA   = 8'h10;
  localparam logic [7:0]  OFS_STATUS      = 8'h14;
  // Field positions
  localparam int          POS_DUAL_BUF    = 17;
  localparam int          POS_CS1         = 14;
  localparam int          POS_XFER_DIR    = 0;
  localparam int          POS_XFER_GO     = 1;
  localparam int          POS_BUSY        = 0;
  // Reset values
  localparam logic [10:0] RST_ADDR        = 11'h000;
  localparam logic [15:0] RST_DATA        = 16'h0000;
  // Transfer timing: strobe held for this many ns, at 20 MHz clock
  localparam int          STROBE_NS       = 100;
  localparam int          CLK_NS          = 50;
  localparam int          STROBE_CYC      = (STROBE_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    PDB_IDLE   = 2'b00,
    PDB_STROBE = 2'b01,
    PDB_DONE   = 2'b10
  } pdb_state_t;
endpackage

// ### hdl/pdb_regs.sv
// Dual-buffer register file of the parallel host port with Wishbone access
// Function
// - Write CS1 bit one asserts chip select 1, zero leaves it low; address pin 14 is always driven zero
// - Read CS1 bit one asserts chip select 1, zero leaves it low; address pin 14 is always driven zero
// - Separate write and read address registers used only when dual buffer on
// - Dual buffer on: read data lands in 16-bit read input data register
// - Dual buffer off: read data returns through shared data-in register
// - Address registers: upper unimplemented bits read zero, writes ignored
// - Read input data register: bits 31 to 16 read zero
// - Low 16 bits of read input data register are the read input value
module pdb_regs
  import pdb_pkg::*;
(
  // Clock and reset
  input  wire logic                     clk_i,
  input  wire logic                     rst_i,
  // Wishbone slave
  input  wire logic                     cyc_i,
  input  wire logic                     stb_i,
  input  wire logic                     we_i,
  input  wire logic [3:0]               sel_i,
  input  wire logic [pdb_pkg::OFS_W-1:0] adr_i,
  input  wire logic [pdb_pkg::DATA_W-1:0] dat_i,
  output logic [pdb_pkg::DATA_W-1:0]    dat_o,
  output logic                          ack_o,
  // Parallel pins
  output logic [pdb_pkg::ADDR_W-1:0]    addr_pins_o,
  output logic                          address_pin_fourteen_o,
  output logic                          cs1_o,
  output logic                          rd_strobe_o,
  output logic                          wr_strobe_o,
  input  wire logic [pdb_pkg::RDATA_W-1:0] data_pins_i,
  // Read input value
  output logic [pdb_pkg::RDATA_W-1:0]   read_input_value_o
);
  import pdb_pkg::*;

  pdb_xfer_if xf ();

  logic                access;
  logic                mapped;
  logic                dual_buffer_enable;
  logic                next_dual;
  logic [ADDR_W-1:0]   write_addr_field;
  logic [ADDR_W-1:0]   next_write_addr_field;
  logic                write_chip_select_one;
  logic                next_wcs;
  logic [ADDR_W-1:0]   read_addr_field;
  logic [ADDR_W-1:0]   next_read_addr_field;
  logic                read_chip_select_one;
  logic                next_rcs;
  logic [RDATA_W-1:0]  read_input_data_reg;
  logic [RDATA_W-1:0]  next_rdin;
  logic [RDATA_W-1:0]  shared_data_in_reg;
  logic [RDATA_W-1:0]  next_din;
  logic                start;
  logic                next_start;
  logic                is_read;
  logic                next_is_read;
  logic [DATA_W-1:0]   rd_word;
  logic [DATA_W-1:0]   wmask;
  logic                wr;

  pdb_wb_slave u_wb (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .adr_i    (adr_i),
    .ack_o    (ack_o),
    .access_o (access),
    .mapped_o (mapped)
  );

  pdb_engine u_eng (
    .clk_i                  (clk_i),
    .rst_i                  (rst_i),
    .xf                     (xf.eng),
    .addr_pins_o            (addr_pins_o),
    .address_pin_fourteen_o (address_pin_fourteen_o),
    .cs1_o                  (cs1_o),
    .rd_strobe_o            (rd_strobe_o),
    .wr_strobe_o            (wr_strobe_o),
    .data_pins_i            (data_pins_i)
  );

  // Byte lanes expand to a bit mask
  genvar g;
  for (g = 0; g < 4; g++) begin : g_lane
    assign wmask[g*8 +: 8] = {8{sel_i[g]}};
  end

  assign wr = access && we_i && mapped;

  always_comb begin
    next_dual    = dual_buffer_enable;
    next_write_addr_field   = write_addr_field;
    next_wcs     = write_chip_select_one;
    next_read_addr_field   = read_addr_field;
    next_rcs     = read_chip_select_one;
    next_rdin    = read_input_data_reg;
    next_din     = shared_data_in_reg;
    next_start   = 1'b0;
    next_is_read = is_read;
    if (wr && adr_i == OFS_CONTROL) begin
      if (sel_i[2]) begin
        next_dual = dat_i[POS_DUAL_BUF];
      end
      if (sel_i[0] && dat_i[POS_XFER_GO] && !xf.busy) begin
        next_start   = 1'b1;
        next_is_read = dat_i[POS_XFER_DIR];
      end
    end else if (wr && adr_i == OFS_DATA_IN) begin
      next_din = (shared_data_in_reg & ~wmask[15:0])
                 | (dat_i[15:0] & wmask[15:0]);
    end else if (wr && adr_i == OFS_WRITE_ADDR) begin
      next_write_addr_field = (write_addr_field & ~wmask[10:0])
                   | (dat_i[10:0] & wmask[10:0]);
      if (sel_i[1]) begin
        next_wcs = dat_i[POS_CS1];
      end
    end else if (wr && adr_i == OFS_READ_ADDR) begin
      next_read_addr_field = (read_addr_field & ~wmask[10:0])
                   | (dat_i[10:0] & wmask[10:0]);
      if (sel_i[1]) begin
        next_rcs = dat_i[POS_CS1];
      end
    end else if (wr && adr_i == OFS_READ_DATA) begin
      next_rdin = (read_input_data_reg & ~wmask[15:0])
                  | (dat_i[15:0] & wmask[15:0]);
    end
    if (xf.done && is_read) begin
      if (dual_buffer_enable) begin
        next_rdin = xf.rdata;
      end else begin
        next_din = xf.rdata;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dual_buffer_enable    <= 1'b0;
      write_addr_field      <= RST_ADDR;
      write_chip_select_one <= 1'b0;
      read_addr_field       <= RST_ADDR;
      read_chip_select_one  <= 1'b0;
      read_input_data_reg   <= RST_DATA;
      shared_data_in_reg    <= RST_DATA;
      start                 <= 1'b0;
      is_read               <= 1'b0;
    end else begin
      dual_buffer_enable    <= next_dual;
      write_addr_field      <= next_write_addr_field;
      write_chip_select_one <= next_wcs;
      read_addr_field       <= next_read_addr_field;
      read_chip_select_one  <= next_rcs;
      read_input_data_reg   <= next_rdin;
      shared_data_in_reg    <= next_din;
      start                 <= next_start;
      is_read               <= next_is_read;
    end
  end

  always_comb begin
    xf.start   = start;
    xf.is_read = is_read;
    if (!dual_buffer_enable) begin
      xf.addr = write_addr_field;
      xf.cs1  = write_chip_select_one;
    end else if (is_read) begin
      xf.addr = read_addr_field;
      xf.cs1  = read_chip_select_one;
    end else begin
      xf.addr = write_addr_field;
      xf.cs1  = write_chip_select_one;
    end
  end

  // Pin 14 sits in the engine, tied to zero; the engine holds CS1 for the whole transfer

  assign read_input_value_o = read_input_data_reg;

  // Read mux: unmapped offsets read zero
  always_comb begin
    rd_word = '0;
    if (adr_i == OFS_CONTROL) begin
      rd_word[POS_DUAL_BUF] = dual_buffer_enable;
    end else if (adr_i == OFS_DATA_IN) begin
      rd_word[15:0] = shared_data_in_reg;
    end else if (adr_i == OFS_WRITE_ADDR) begin
      rd_word[10:0]   = write_addr_field;
      rd_word[POS_CS1] = write_chip_select_one;
    end else if (adr_i == OFS_READ_ADDR) begin
      rd_word[10:0]   = read_addr_field;
      rd_word[POS_CS1] = read_chip_select_one;
    end else if (adr_i == OFS_READ_DATA) begin
      rd_word[15:0] = read_input_data_reg;
    end else if (adr_i == OFS_STATUS) begin
      rd_word[POS_BUSY] = xf.busy;
    end
  end

  logic [DATA_W-1:0] dat_q;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_q <= '0;
    end else begin
      dat_q <= rd_word;
    end
  end
  assign dat_o = dat_q;

  // Read data lands in the right register one cycle after done
  dual_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    xf.done && is_read && dual_buffer_enable && !wr
    |=> read_input_data_reg == $past(xf.rdata))
    else $error("dual read data lost");
  shared_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    xf.done && is_read && !dual_buffer_enable
    |=> shared_data_in_reg == $past(xf.rdata)
        && read_input_data_reg == $past(read_input_data_reg))
    else $error("shared read misrouted");
  rdin_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !dual_buffer_enable && !(wr && adr_i == OFS_READ_DATA)
    |=> $stable(read_input_data_reg))
    else $error("dedicated data register touched");
  din_keep_a: assert property (@(posedge clk_i) disable iff (rst_i)
    dual_buffer_enable && !(wr && adr_i == OFS_DATA_IN)
    |=> $stable(shared_data_in_reg))
    else $error("shared data register touched");

  upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adr_i == OFS_READ_DATA) |=> dat_o[31:16] == 16'h0000)
    else $error("read data upper bits set");
  addr_upper_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adr_i == OFS_WRITE_ADDR || adr_i == OFS_READ_ADDR)
    |=> dat_o[31:15] == 17'h0 && dat_o[13:11] == 3'h0)
    else $error("address upper bits set");
  value_out_a: assert property (@(posedge clk_i) disable iff (rst_i)
    read_input_value_o == read_input_data_reg)
    else $error("read input value mismatch");
  ctl_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (adr_i == OFS_CONTROL) |=> dat_o[POS_DUAL_BUF] == $past(dual_buffer_enable))
    else $error("dual buffer bit reads wrong");

  write_addr_field_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == OFS_WRITE_ADDR && sel_i[0]
    |=> write_addr_field[7:0] == $past(dat_i[7:0]))
    else $error("write address field not stored");
  read_addr_field_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == OFS_READ_ADDR && sel_i[0]
    |=> read_addr_field[7:0] == $past(dat_i[7:0]))
    else $error("read address field not stored");
  wcs_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == OFS_WRITE_ADDR && sel_i[1]
    |=> write_chip_select_one == $past(dat_i[POS_CS1]))
    else $error("write chip select bit not stored");
  rcs_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr && adr_i == OFS_READ_ADDR && sel_i[1]
    |=> read_chip_select_one == $past(dat_i[POS_CS1]))
    else $error("read chip select bit not stored");

  sequence start_rd_s;
    start && is_read && dual_buffer_enable;
  endsequence
  sequence start_wa_s;
    start && (!is_read || !dual_buffer_enable);
  endsequence
  sequence strobe_s;
    (rd_strobe_o || wr_strobe_o) [*2] ##1 !(rd_strobe_o || wr_strobe_o);
  endsequence
  dual_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_rd_s |=> addr_pins_o == $past(read_addr_field))
    else $error("read address not driven");
  wr_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start && !is_read |=> addr_pins_o == $past(write_addr_field))
    else $error("write address not driven");
  single_addr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start && !dual_buffer_enable |=> addr_pins_o == $past(write_addr_field))
    else $error("single buffer address wrong");
  cs_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !xf.busy |-> !cs1_o)
    else $error("chip select active while idle");
  rcs_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_rd_s ##1 xf.busy |-> cs1_o == $past(read_chip_select_one))
    else $error("read chip select wrong");
  wcs_pin_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_wa_s ##1 xf.busy |-> cs1_o == $past(write_chip_select_one))
    else $error("write chip select wrong");
  strobe_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> strobe_s)
    else $error("strobe length wrong");
  ack_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
endmodule

// ### hdl/pdb_wb_slave.sv
// Wishbone classic handshake: one-cycle ack and unmapped-address detection
module pdb_wb_slave
  import pdb_pkg::*;
(
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Bus request
  input  wire logic               cyc_i,
  input  wire logic               stb_i,
  input  wire logic [OFS_W-1:0]   adr_i,
  // Access strobes
  output logic                    ack_o,
  output logic                    access_o,
  output logic                    mapped_o
);
  logic ack;
  logic next_ack;

  always_comb begin
    next_ack = cyc_i && stb_i && !ack;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  assign ack_o    = ack;
  assign access_o = cyc_i && stb_i && ack;
  assign mapped_o = (adr_i[1:0] == 2'b00) && (adr_i <= OFS_STATUS);
endmodule

// ### hdl/pdb_xfer_if.sv
// Interface: transfer request and result between register file and pin engine
interface pdb_xfer_if;
  logic        start;
  logic        is_read;
  logic [10:0] addr;
  logic        cs1;
  logic        busy;
  logic        done;
  logic [15:0] rdata;
  modport regs (output start, output is_read, output addr, output cs1,
                input busy, input done, input rdata);
  modport eng  (input start, input is_read, input addr, input cs1,
                output busy, output done, output rdata);
endinterface

// ### testbench/pdb_mem_model.sv
// Far-side device model: answers read strobes with address-derived data
module pdb_mem_model
  import pdb_pkg::*;
(
  // Clock
  input  wire logic               clk_i,
  // Pins from the port
  input  wire logic [ADDR_W-1:0]  addr_pins_i,
  input  wire logic               cs1_i,
  input  wire logic               rd_strobe_i,
  // Data back to the port
  output logic [RDATA_W-1:0]      data_pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [RDATA_W-1:0] answer;
  logic [RDATA_W-1:0] idle_val;
  initial idle_val = 16'h0f0f;
  assign answer = {addr_pins_i, 4'h0, cs1_i} ^ 16'h00a5;
  // Released bus toggles so a stale value is never mistaken for data
  always @(posedge clk_i) begin
    idle_val <= rd_strobe_i ? answer : ~idle_val;
  end
  assign data_pins_o = rd_strobe_i ? answer : idle_val;
endmodule

// ### testbench/tb_top.sv
// Testbench: register access and transfers of the dual-buffer port
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pdb_pkg::*;
  logic               clk_i = 1'b0;
  logic               rst_i = 1'b1;
  logic               cyc_i = 1'b0;
  logic               stb_i = 1'b0;
  logic               we_i  = 1'b0;
  logic [3:0]         sel_i = 4'hf;
  logic [OFS_W-1:0]   adr_i = 8'h00;
  logic [DATA_W-1:0]  dat_i = 32'h0;
  logic [DATA_W-1:0]  dat_o;
  logic               ack_o;
  logic [ADDR_W-1:0]  addr_pins_o;
  logic               address_pin_fourteen_o;
  logic               cs1_o;
  logic               rd_strobe_o;
  logic               wr_strobe_o;
  logic [RDATA_W-1:0] data_pins_i;
  logic [RDATA_W-1:0] read_input_value_o;
  int                 errors = 0;
  int                 n_compared = 0;

  always #25 clk_i = ~clk_i;

  pdb_regs i_pdb_regs (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i),
    .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .addr_pins_o(addr_pins_o),
    .address_pin_fourteen_o(address_pin_fourteen_o), .cs1_o(cs1_o),
    .rd_strobe_o(rd_strobe_o), .wr_strobe_o(wr_strobe_o),
    .data_pins_i(data_pins_i), .read_input_value_o(read_input_value_o));

  pdb_mem_model i_pdb_mem_model (.clk_i(clk_i), .addr_pins_i(addr_pins_o),
    .cs1_i(cs1_o), .rd_strobe_i(rd_strobe_o), .data_pins_o(data_pins_i));

  task automatic stop_test();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic fail_wait();
    errors++;
    $display("ERROR %0t wait bound used up", $time);
    stop_test();
  endtask

  // One classic cycle; the slave's ack ends it, a bound cuts a hang
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_wait();
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask

  function automatic logic [15:0] dev_data(input logic [10:0] a,
                                           input logic cs);
    return {a, 4'h0, cs} ^ 16'h00a5;
  endfunction

  // Start one transfer, check pins during the strobe, wait for idle
  task automatic xfer(input logic [31:0] ctl, input logic [10:0] ea,
                      input logic ecs);
    int n;
    logic [31:0] r;
    wb(1'b1, OFS_CONTROL, ctl, r);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(rd_strobe_o | wr_strobe_o) && n < 20);
    if (n >= 20) fail_wait();
    check({31'h0, rd_strobe_o}, {31'h0, ctl[POS_XFER_DIR]});
    check({31'h0, wr_strobe_o}, {31'h0, ~ctl[POS_XFER_DIR]});
    check({21'h0, addr_pins_o}, {21'h0, ea});
    check({31'h0, cs1_o}, {31'h0, ecs});
    check({31'h0, address_pin_fourteen_o}, 32'h0);
    n = 0;
    do begin
      wb(1'b0, OFS_STATUS, 32'h0, r);
      n++;
    end while (r[POS_BUSY] !== 1'b0 && n < 20);
    if (n >= 20) fail_wait();
  endtask

  task automatic t_reset_and_width();
    logic [31:0] r;
    check({16'h0, read_input_value_o}, 32'h0);
    wb(1'b0, OFS_WRITE_ADDR, 32'h0, r);
    check(r, 32'h0);
    wb(1'b0, OFS_READ_ADDR, 32'h0, r);
    check(r, 32'h0);
    wb(1'b0, OFS_READ_DATA, 32'h0, r);
    check(r, 32'h0);
    wb(1'b1, OFS_WRITE_ADDR, 32'hffff_ffff, r);
    wb(1'b0, OFS_WRITE_ADDR, 32'h0, r);
    check(r, 32'h0000_47ff);
    sel_i <= 4'h1;
    wb(1'b1, OFS_WRITE_ADDR, 32'h0000_0000, r);
    sel_i <= 4'hf;
    wb(1'b0, OFS_WRITE_ADDR, 32'h0, r);
    check(r, 32'h0000_4700);
    wb(1'b1, OFS_READ_ADDR, 32'hffff_ffff, r);
    wb(1'b0, OFS_READ_ADDR, 32'h0, r);
    check(r, 32'h0000_47ff);
    wb(1'b1, OFS_READ_DATA, 32'hffff_1234, r);
    wb(1'b0, OFS_READ_DATA, 32'h0, r);
    check(r, 32'h0000_1234);
    check({16'h0, read_input_value_o}, 32'h0000_1234);
    wb(1'b0, 8'hf0, 32'h0, r);
    check(r, 32'h0);
  endtask

  task automatic t_dual_transfers();
    logic [31:0] r;
    logic [31:0] dual;
    dual = 32'h1 << POS_DUAL_BUF;
    wb(1'b1, OFS_WRITE_ADDR, 32'h0000_0055, r);
    wb(1'b1, OFS_READ_ADDR, 32'h0000_4123, r);
    xfer(dual | 32'h3, 11'h123, 1'b1);
    wb(1'b0, OFS_READ_DATA, 32'h0, r);
    check(r, {16'h0, dev_data(11'h123, 1'b1)});
    check({16'h0, read_input_value_o},
          {16'h0, dev_data(11'h123, 1'b1)});
    wb(1'b0, OFS_CONTROL, 32'h0, r);
    check(r, dual);
    xfer(dual | 32'h2, 11'h055, 1'b0);
    wb(1'b1, OFS_WRITE_ADDR, 32'h0000_4400, r);
    xfer(dual | 32'h2, 11'h400, 1'b1);
    wb(1'b1, OFS_WRITE_ADDR, 32'h0000_0000, r);
    wb(1'b1, OFS_READ_ADDR, 32'h0000_02aa, r);
    xfer(dual | 32'h3, 11'h2aa, 1'b0);
    wb(1'b0, OFS_READ_DATA, 32'h0, r);
    check(r, {16'h0, dev_data(11'h2aa, 1'b0)});
  endtask

  // Single-buffer read must leave the dedicated data register alone
  task automatic t_single_read();
    logic [31:0] r;
    wb(1'b1, OFS_WRITE_ADDR, 32'h0000_0333, r);
    xfer(32'h3, 11'h333, 1'b0);
    wb(1'b0, OFS_DATA_IN, 32'h0, r);
    check({16'h0, r[15:0]}, {16'h0, dev_data(11'h333, 1'b0)});
    wb(1'b0, OFS_READ_DATA, 32'h0, r);
    check(r, {16'h0, dev_data(11'h2aa, 1'b0)});
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset_and_width();
    t_dual_transfers();
    t_single_read();
    stop_test();
  end
endmodule
